// ===== design/fsmb_fifo.sv
`timescale 1ns/1ps
module fsmb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int PUSH_MAX = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side: push_cnt entries, lowest lane first; caller keeps it within free space
  input wire logic [$clog2(PUSH_MAX+1)-1:0] push_cnt,
  input wire logic [PUSH_MAX*WIDTH-1:0] push_data,
  // drain side
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam int PW = $clog2(PUSH_MAX+1);

  if (DEPTH != (1 << AW) || PUSH_MAX > DEPTH || PUSH_MAX < 1) begin : g_bad
    $error("fsmb_fifo: depth must be a power of two and at least push_max");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic pop_ok;

  assign pop_ok = pop && (cnt_q != '0);
  assign head = mem[rp_q];
  assign count = cnt_q;
  assign full = (cnt_q == CW'(DEPTH));
  assign empty = (cnt_q == '0);

  always_ff @(posedge clk) begin
    for (int i = 0; i < PUSH_MAX; i++) begin
      if (PW'(i) < push_cnt) begin
        mem[AW'(wp_q + AW'(i))] <= push_data[i*WIDTH +: WIDTH];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= AW'(wp_q + AW'(push_cnt));
      rp_q <= AW'(rp_q + AW'(pop_ok));
      cnt_q <= CW'(cnt_q + CW'(push_cnt) - CW'(pop_ok));
    end
  end

endmodule

// ===== design/fsmb_mailbox_block.sv
`timescale 1ns/1ps
// Contract
// - register port plus two eight-entry byte FIFOs
// - written bytes reach peer; received bytes raise interrupt
// - frame-start writes set ninth marker bit
// - plain data writes clear marker bit
// - status bit 7 shows receive head marker
// - marker lets receiver spot broken sequences
// - word write pushes four bytes at once, or only as many as fit in the transmit FIFO
// - command interrupt on programmable marked-byte match
// - single interrupt gated by enable bits
// - receive and transmit DMA ready outputs
// - DMA moves bytes without other masters
// - sender never overruns peer receive FIFO
// - registers and control run on bus clock
// - data clock domain crossed safely
// - link rate one byte per sampled data clock rise, below the nominal 50 megabytes per second
// - reset to zero except soft reset bit, held until enabled
// - soft reset bit 15 holds block reset
// - data registers at 0x10 to 0x1C
module fsmb_mailbox_block #(
  parameter int DEPTH = fsmb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [fsmb_pkg::ADDR_W-1:0] addr,
  input wire logic [fsmb_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [fsmb_pkg::DATA_W-1:0] rdata,
  // link to the peer mailbox
  input wire logic data_clk,
  input wire logic [fsmb_pkg::ENTRY_W-1:0] link_rx_data,
  input wire logic link_rx_valid,
  input wire logic peer_rx_ready,
  output logic [fsmb_pkg::ENTRY_W-1:0] link_tx_data,
  output logic link_tx_valid,
  output logic link_rx_ready,
  // interrupt and dma flow control
  output logic mailbox_irq_out,
  output logic rx_dma_request,
  output logic tx_dma_request
);
  import fsmb_pkg::*;

  localparam int CW = $clog2(DEPTH+1);
  localparam int PW = $clog2(WORD_BYTES+1);
  localparam int SYNC_W = ENTRY_W + 3;

  if (DEPTH < RX_READY_MARGIN + 1 || DEPTH < WORD_BYTES) begin : g_bad
    $error("fsmb_mailbox_block: depth too small for word push and link margin");
  end

  // control registers
  logic soft_rst_q;
  logic ctl_en_q;
  logic ctl_loop_q;
  logic [NUM_SRC-1:0] int_en_q;
  logic [2*BYTE_W-1:0] cmd_match_q;
  logic tx_ovf_q;
  logic rx_unf_q;
  logic cmd_hit_q;
  logic irq_q;
  logic [DATA_W-1:0] rdata_q;
  logic blk_rst;
  logic fifo_rst;

  assign blk_rst = rst || soft_rst_q;
  assign fifo_rst = blk_rst || !ctl_en_q;

  // fifo wiring
  logic [PW-1:0] tx_push_cnt;
  logic [WORD_BYTES*ENTRY_W-1:0] tx_push_data;
  logic tx_pop;
  logic [ENTRY_W-1:0] tx_head;
  logic [CW-1:0] tx_count;
  logic tx_full;
  logic tx_empty;
  logic [PW-1:0] rx_push_cnt;
  logic [WORD_BYTES*ENTRY_W-1:0] rx_push_data;
  logic rx_pop;
  logic [ENTRY_W-1:0] rx_head;
  logic [CW-1:0] rx_count;
  logic rx_full;
  logic rx_empty;

  fsmb_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH), .PUSH_MAX(WORD_BYTES)) u_tx_fifo (
    .clk(mclk),
    .rst(fifo_rst),
    .push_cnt(tx_push_cnt),
    .push_data(tx_push_data),
    .pop(tx_pop),
    .head(tx_head),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  fsmb_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH), .PUSH_MAX(WORD_BYTES)) u_rx_fifo (
    .clk(mclk),
    .rst(fifo_rst),
    .push_cnt(rx_push_cnt),
    .push_data(rx_push_data),
    .pop(rx_pop),
    .head(rx_head),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  // bus decode
  logic wr_byte;
  logic wr_word;
  logic wr_mark;
  logic rd_data;
  logic [CW-1:0] tx_free;
  logic tx_drop;

  assign wr_byte = wr && ctl_en_q && (addr == ADR_DATA_BYTE || addr == ADR_FRAME_BYTE);
  assign wr_word = wr && ctl_en_q && (addr == ADR_DATA_WORD || addr == ADR_FRAME_WORD);
  assign wr_mark = (addr == ADR_FRAME_BYTE || addr == ADR_FRAME_WORD);
  assign rd_data = rd && ctl_en_q && (addr == ADR_DATA_BYTE || addr == ADR_DATA_WORD ||
                                      addr == ADR_FRAME_BYTE || addr == ADR_FRAME_WORD);
  assign tx_free = CW'(DEPTH) - tx_count;

  // bytes that do not fit are dropped, lowest lanes keep their place
  always_comb begin
    tx_push_cnt = '0;
    tx_drop = 1'b0;
    for (int i = 0; i < WORD_BYTES; i++) begin
      tx_push_data[i*ENTRY_W +: ENTRY_W] = {wr_mark, wdata[i*BYTE_W +: BYTE_W]};
    end
    if (wr_byte) begin
      tx_push_cnt = tx_full ? '0 : PW'(1);
      tx_drop = tx_full;
    end else if (wr_word) begin
      if (tx_free >= CW'(WORD_BYTES)) begin
        tx_push_cnt = PW'(WORD_BYTES);
      end else begin
        tx_push_cnt = PW'(tx_free);
        tx_drop = 1'b1;
      end
    end
  end

  // link pin synchroniser: stage 2 and 3 must agree before a change counts
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] filt_q;
  logic [SYNC_W-1:0] filt_d;
  logic lclk_f;
  logic lclk_rise;
  logic lclk_fall;
  logic [ENTRY_W-1:0] rxd_f;
  logic rxv_f;
  logic peer_rdy_f;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {data_clk, peer_rx_ready, link_rx_valid, link_rx_data};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      filt_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt_d;
    end
  end

  assign lclk_f = filt_q[SYNC_W-1];
  assign lclk_rise = filt_d[SYNC_W-1] && !lclk_f;
  assign lclk_fall = !filt_d[SYNC_W-1] && lclk_f;
  assign peer_rdy_f = filt_q[ENTRY_W+1];
  assign rxv_f = filt_q[ENTRY_W];
  assign rxd_f = filt_q[ENTRY_W-1:0];

  // transfer engine: sends on the data clock rising edge, peer samples on the next rise
  logic link_on;
  logic send_now;
  logic loop_move;
  logic link_take;
  logic [ENTRY_W-1:0] link_tx_data_q;
  logic link_tx_valid_q;
  logic link_rx_ready_q;

  assign link_on = ctl_en_q && !ctl_loop_q;
  // at most one byte per sampled data clock period, well below the nominal link rate
  assign send_now = lclk_rise && link_on && !tx_empty && peer_rdy_f;
  assign loop_move = ctl_en_q && ctl_loop_q && !tx_empty && !rx_full;
  assign link_take = lclk_fall && link_on && rxv_f && !rx_full;
  assign tx_pop = send_now || loop_move;
  assign rx_pop = rd_data;
  assign rx_push_cnt = (loop_move || link_take) ? PW'(1) : '0;

  always_comb begin
    rx_push_data = '0;
    rx_push_data[ENTRY_W-1:0] = ctl_loop_q ? tx_head : rxd_f;
  end

  always_ff @(posedge mclk) begin
    if (fifo_rst) begin
      link_tx_data_q <= '0;
      link_tx_valid_q <= 1'b0;
    end else if (lclk_rise) begin
      link_tx_data_q <= send_now ? tx_head : link_tx_data_q;
      link_tx_valid_q <= send_now;
    end
  end

  // margin covers the synchroniser and one data clock period of lag at the peer
  always_ff @(posedge mclk) begin
    if (fifo_rst) begin
      link_rx_ready_q <= 1'b0;
    end else begin
      link_rx_ready_q <= link_on && (rx_count <= CW'(DEPTH - RX_READY_MARGIN));
    end
  end

  assign link_tx_data = link_tx_data_q;
  assign link_tx_valid = link_tx_valid_q;
  assign link_rx_ready = link_rx_ready_q;

  // command match on marked bytes entering the receive fifo
  logic cmd_match_now;
  assign cmd_match_now = (rx_push_cnt != '0) && rx_push_data[MARK_BIT] &&
    (((rx_push_data[BYTE_W-1:0] ^ cmd_match_q[CM_VAL_LSB +: BYTE_W]) &
      cmd_match_q[CM_MASK_LSB +: BYTE_W]) == '0);

  // control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      soft_rst_q <= SOFT_RESET_RST;
    end else if (wr && addr == ADR_SOFT_RESET) begin
      soft_rst_q <= wdata[SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      ctl_en_q <= 1'b0;
      ctl_loop_q <= 1'b0;
      int_en_q <= '0;
      cmd_match_q <= '0;
    end else if (wr) begin
      if (addr == ADR_CONTROL) begin
        ctl_en_q <= wdata[CTL_ENABLE];
        ctl_loop_q <= wdata[CTL_LOOPBACK];
      end
      if (addr == ADR_INT_ENABLE) begin
        int_en_q <= wdata[NUM_SRC-1:0];
      end
      if (addr == ADR_CMD_MATCH) begin
        cmd_match_q <= wdata[2*BYTE_W-1:0];
      end
    end
  end

  // sticky flags: write one to clear, a new event in the same cycle wins
  logic st_clr;
  assign st_clr = wr && addr == ADR_STATUS;

  always_ff @(posedge mclk) begin
    if (fifo_rst) begin
      tx_ovf_q <= 1'b0;
      rx_unf_q <= 1'b0;
      cmd_hit_q <= 1'b0;
    end else begin
      tx_ovf_q <= tx_drop || (tx_ovf_q && !(st_clr && wdata[ST_TX_OVF]));
      rx_unf_q <= (rd_data && rx_empty) || (rx_unf_q && !(st_clr && wdata[ST_RX_UNF]));
      cmd_hit_q <= cmd_match_now || (cmd_hit_q && !(st_clr && wdata[ST_CMD]));
    end
  end

  // status and interrupt
  logic [NUM_SRC-1:0] src;
  logic [DATA_W-1:0] status_w;
  logic irq_d;

  assign irq_d = |(src & int_en_q);

  always_comb begin
    src = '0;
    src[ST_TX_OK] = ctl_en_q && !tx_full;
    src[ST_RX_OK] = ctl_en_q && !rx_empty;
    src[ST_TX_OVF] = tx_ovf_q;
    src[ST_RX_UNF] = rx_unf_q;
    src[ST_CMD] = cmd_hit_q;
    status_w = '0;
    status_w[NUM_SRC-1:0] = src;
    status_w[ST_RX_MARK] = !rx_empty && rx_head[MARK_BIT];
  end

  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign mailbox_irq_out = irq_q;
  assign rx_dma_request = src[ST_RX_OK];
  assign tx_dma_request = src[ST_TX_OK];

  // read port: data one cycle after the strobe, unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (rd) begin
      case (addr)
        ADR_CONTROL: rdata_q <= DATA_W'({ctl_loop_q, ctl_en_q});
        ADR_STATUS: rdata_q <= status_w;
        ADR_INT_ENABLE: rdata_q <= DATA_W'(int_en_q);
        ADR_SOFT_RESET: rdata_q <= DATA_W'({soft_rst_q, {SOFT_RESET_BIT{1'b0}}});
        ADR_CMD_MATCH: rdata_q <= DATA_W'(cmd_match_q);
        ADR_DATA_BYTE, ADR_DATA_WORD, ADR_FRAME_BYTE, ADR_FRAME_WORD: begin
          rdata_q <= (ctl_en_q && !rx_empty) ? DATA_W'(rx_head) : '0;
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  assign rdata = rdata_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_frame_mark;
    (wr && addr == ADR_FRAME_BYTE && ctl_en_q && tx_empty && !soft_rst_q) |=> tx_head[MARK_BIT];
  endproperty
  a_frame_mark: assert property (p_frame_mark) else $error("frame byte lost marker");

  property p_data_nomark;
    (wr && addr == ADR_DATA_BYTE && ctl_en_q && tx_empty && !soft_rst_q) |=> !tx_head[MARK_BIT];
  endproperty
  a_data_nomark: assert property (p_data_nomark) else $error("data byte marked");

  property p_word_push;
    (wr_word && tx_empty && !soft_rst_q) |=> tx_count == CW'(WORD_BYTES);
  endproperty
  a_word_push: assert property (p_word_push) else $error("word write not four bytes");

  property p_status_mark;
    (rd && addr == ADR_STATUS) |=> rdata[ST_RX_MARK] == $past(status_w[ST_RX_MARK]);
  endproperty
  a_status_mark: assert property (p_status_mark) else $error("status marker wrong");

  property p_overflow;
    (wr_byte && tx_full && !soft_rst_q) |=> tx_ovf_q ##1 (tx_ovf_q || $past(st_clr));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag missing");

  property p_underflow;
    (rd_data && rx_empty && !soft_rst_q) |=> rx_unf_q;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow flag missing");

  property p_irq_gate;
    !blk_rst ##1 !blk_rst |-> mailbox_irq_out == $past(irq_d);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

  property p_send;
    send_now && !fifo_rst |=> link_tx_valid && link_tx_data == $past(tx_head);
  endproperty
  a_send: assert property (p_send) else $error("link byte not sent");

  property p_peer_flow;
    $rose(link_tx_valid) |-> $past(peer_rdy_f);
  endproperty
  a_peer_flow: assert property (p_peer_flow) else $error("sent without peer ready");

  property p_soft_hold;
    soft_rst_q |=> !ctl_en_q && !rx_dma_request && !tx_dma_request && !mailbox_irq_out;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft reset not holding");

  property p_cmd_hit;
    cmd_match_now && !fifo_rst |=> cmd_hit_q;
  endproperty
  a_cmd_hit: assert property (p_cmd_hit) else $error("command match lost");

  c_word: cover property (wr_word && tx_free >= CW'(WORD_BYTES));
  c_loop: cover property (loop_move);
  c_link_rx: cover property (link_take);
  c_cmd: cover property (cmd_match_now);

endmodule

// ===== design/fsmb_pkg.sv
package fsmb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int ENTRY_W = 9;
  localparam int MARK_BIT = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_BYTES = 4;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_INT_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_DATA_BYTE = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_DATA_WORD = 8'h14;
  localparam logic [ADDR_W-1:0] ADR_FRAME_BYTE = 8'h18;
  localparam logic [ADDR_W-1:0] ADR_FRAME_WORD = 8'h1C;
  localparam logic [ADDR_W-1:0] ADR_SOFT_RESET = 8'h20;
  localparam logic [ADDR_W-1:0] ADR_CMD_MATCH = 8'h24;

  // control fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_LOOPBACK = 1;
  localparam int SOFT_RESET_BIT = 15;
  localparam logic SOFT_RESET_RST = 1'b1;

  // status / interrupt enable fields (same positions in both)
  localparam int ST_TX_OK = 0;
  localparam int ST_RX_OK = 1;
  localparam int ST_TX_OVF = 2;
  localparam int ST_RX_UNF = 3;
  localparam int ST_CMD = 4;
  localparam int ST_RX_MARK = 7;
  localparam int NUM_SRC = 5;

  // command match register fields
  localparam int CM_VAL_LSB = 0;
  localparam int CM_MASK_LSB = 8;

  // data clock and link figures
  localparam longint MCLK_HZ = 25_000_000;
  localparam longint DATA_CLK_HZ = 50_000_000;
  localparam longint LINK_BYTES_PER_S = 50_000_000;
  // free entries needed before telling the peer it may send
  localparam int RX_READY_MARGIN = 3;

endpackage

// ===== dv/fsmb_peer_model.sv
`timescale 1ns/1ps
module fsmb_peer_model (
  // link clock
  output logic data_clk,
  // bytes toward the block
  output logic [8:0] link_rx_data,
  output logic link_rx_valid,
  output logic peer_rx_ready,
  // bytes from the block
  input wire logic [8:0] link_tx_data,
  input wire logic link_tx_valid,
  input wire logic link_rx_ready,
  // bench control
  input wire logic stall
);
  logic [8:0] send_q[$];
  logic [8:0] got_q[$];

  // free-running oscillator, phase unrelated to mclk
  initial begin
    data_clk = 1'b0;
    link_rx_valid = 1'b0;
    link_rx_data = 9'h000;
    #7;
    forever #160 data_clk = ~data_clk;
  end

  assign peer_rx_ready = ~stall;

  // block launches a few mclk after our rise, so the byte is settled at the next rise
  always @(posedge data_clk) begin
    if (link_tx_valid === 1'b1) begin
      got_q.push_back(link_tx_data);
    end
    if (send_q.size() > 0 && link_rx_ready === 1'b1) begin
      link_rx_data <= send_q.pop_front();
      link_rx_valid <= 1'b1;
    end else begin
      // idle lines toggle so a stale byte is never mistaken for a fresh one
      link_rx_data <= ~link_rx_data;
      link_rx_valid <= 1'b0;
    end
  end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  import fsmb_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [2:0] n; logic m;} fsmb_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall = 1'b1;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rv;
  logic data_clk;
  logic link_rx_valid;
  logic peer_rx_ready;
  logic link_tx_valid;
  logic link_rx_ready;
  logic [ENTRY_W-1:0] link_rx_data;
  logic [ENTRY_W-1:0] link_tx_data;
  logic mailbox_irq_out;
  logic rx_dma_request;
  logic tx_dma_request;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  fsmb_row_t rows[4] = '{
    '{ADR_DATA_BYTE, 32'hFFFFFFA7, 3'd1, 1'b0},
    '{ADR_FRAME_BYTE, 32'h0000005C, 3'd1, 1'b1},
    '{ADR_DATA_WORD, 32'h44332211, 3'd4, 1'b0},
    '{ADR_FRAME_WORD, 32'h8899AABB, 3'd4, 1'b1}};
  logic [8:0] tx_exp[8] = '{9'h001, 9'h002, 9'h003, 9'h004, 9'h105, 9'h006, 9'h111, 9'h122};

  always #20 mclk = ~mclk;

  fsmb_mailbox_block dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .data_clk(data_clk), .link_rx_data(link_rx_data),
    .link_rx_valid(link_rx_valid), .peer_rx_ready(peer_rx_ready),
    .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid),
    .link_rx_ready(link_rx_ready), .mailbox_irq_out(mailbox_irq_out),
    .rx_dma_request(rx_dma_request), .tx_dma_request(tx_dma_request));

  fsmb_peer_model peer (.data_clk(data_clk), .link_rx_data(link_rx_data),
    .link_rx_valid(link_rx_valid), .peer_rx_ready(peer_rx_ready),
    .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid),
    .link_rx_ready(link_rx_ready), .stall(stall));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR %0t run did not finish", $time);
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    // held by soft reset: control and data writes must not land
    wr_reg(ADR_CONTROL, 32'h00000001);
    wr_reg(ADR_DATA_BYTE, 32'h00000005);
    rd_reg(ADR_SOFT_RESET, rv);
    check(32'(rv[SOFT_RESET_BIT]), 32'h1, "soft reset value");
    rd_reg(ADR_CONTROL, rv);
    check(rv, 32'h0, "control while held");
    rd_reg(ADR_STATUS, rv);
    check(rv, 32'h0, "status at reset");
    rd_reg(8'h3C, rv);
    check(rv, 32'h0, "unmapped read");
    check(32'({tx_dma_request, rx_dma_request, mailbox_irq_out, link_tx_valid}), 32'h0,
      "outputs idle");
    $display("test reset done");

    wr_reg(ADR_SOFT_RESET, 32'h0);
    wr_reg(ADR_CONTROL, 32'h00000003);
    for (int r = 0; r < 4; r++) begin
      wr_reg(rows[r].a, rows[r].d);
      repeat (6) @(posedge mclk);
      for (int b = 0; b < int'(rows[r].n); b++) begin
        rd_reg(ADR_STATUS, rv);
        check(32'(rv[ST_RX_MARK]), 32'(rows[r].m), "head marker");
        rd_reg(ADR_DATA_BYTE, rv);
        check(rv, {23'h0, rows[r].m, rows[r].d[8*b +: 8]}, "looped byte");
      end
    end
    // match register still zero, so any marked byte counts as a command
    rd_reg(ADR_STATUS, rv);
    check(32'(rv[ST_CMD]), 32'h1, "unmasked marker matched");
    wr_reg(ADR_STATUS, 32'h0000001C);
    $display("test loopback table done");

    // peer stalled: fill tx, overflow a word in mid-push
    wr_reg(ADR_CONTROL, 32'h00000001);
    wr_reg(ADR_INT_ENABLE, 32'h00000004);
    wr_reg(ADR_DATA_WORD, 32'h04030201);
    wr_reg(ADR_FRAME_BYTE, 32'h00000005);
    wr_reg(ADR_DATA_BYTE, 32'h00000006);
    check(32'(mailbox_irq_out), 32'h0, "no irq yet");
    check(32'(tx_dma_request), 32'h1, "tx room");
    wr_reg(ADR_FRAME_WORD, 32'h44332211);
    // a byte write into the full fifo must be dropped as well
    wr_reg(ADR_DATA_BYTE, 32'h00000077);
    check(32'(tx_dma_request), 32'h0, "tx full");
    rd_reg(ADR_STATUS, rv);
    check(32'(rv[4:0]), 32'h4, "overflow status");
    check(32'(mailbox_irq_out), 32'h1, "overflow irq");
    check(32'(peer.got_q.size()), 32'h0, "nothing sent while stalled");
    wr_reg(ADR_INT_ENABLE, 32'h0);
    @(posedge mclk);
    #1;
    check(32'(mailbox_irq_out), 32'h0, "irq off after enable cleared");
    wr_reg(ADR_STATUS, 32'h00000004);
    rd_reg(ADR_STATUS, rv);
    check(32'(rv[ST_TX_OVF]), 32'h0, "overflow cleared");
    stall <= 1'b0;
    repeat (300) begin
      if (peer.got_q.size() >= 8) break;
      @(posedge mclk);
    end
    check(32'(peer.got_q.size()), 32'h8, "bytes at peer");
    for (int i = 0; i < 8 && i < peer.got_q.size(); i++) begin
      check(32'(peer.got_q[i]), 32'(tx_exp[i]), "byte at peer");
    end
    $display("test overflow and send done");

    rd_reg(ADR_DATA_BYTE, rv);
    check(rv, 32'h0, "empty read");
    rd_reg(ADR_STATUS, rv);
    check(32'(rv[ST_RX_UNF]), 32'h1, "underflow flag");
    wr_reg(ADR_STATUS, 32'h00000008);
    $display("test underflow done");

    // more bytes than the rx fifo holds: flow control must keep them all
    wr_reg(ADR_CMD_MATCH, 32'h0000FFA5);
    wr_reg(ADR_INT_ENABLE, 32'h00000010);
    peer.send_q.push_back(9'h1A5);
    for (int k = 1; k < 10; k++) begin
      peer.send_q.push_back(9'(k));
    end
    repeat (400) begin
      if (link_rx_ready === 1'b0) break;
      @(posedge mclk);
    end
    check(32'(link_rx_ready), 32'h0, "rx ready dropped");
    repeat (40) @(posedge mclk);
    check(32'(rx_dma_request), 32'h1, "rx dma request");
    rd_reg(ADR_STATUS, rv);
    check(32'({rv[ST_RX_MARK], rv[ST_CMD], rv[ST_RX_OK]}), 32'h7, "command seen");
    check(32'(mailbox_irq_out), 32'h1, "command irq");
    for (int i = 0; i < 10; i++) begin
      repeat (100) begin
        rd_reg(ADR_STATUS, rv);
        if (rv[ST_RX_OK] === 1'b1) break;
      end
      rd_reg(ADR_DATA_BYTE, rv);
      check(rv, (i == 0) ? 32'h1A5 : 32'(i), "received byte");
    end
    check(32'(rx_dma_request), 32'h0, "rx drained");
    $display("test receive done");
    conclude();
  end
endmodule
